// File: fbw_pkg.sv
// Purpose: shared constants for the full-bridge waveform steering block
// Assumes: APB data 32 bits, 8-bit registers in the low byte of each word
// Notes:   printed offsets are word indices, byte address = 4 * index
package fbw_pkg;

  // ---------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;

  // ---------------------------------------------------------------
  // register indices
  // ---------------------------------------------------------------
  localparam logic [15:0] IDX_CLOCK_SRC  = 16'h3F52;
  localparam logic [15:0] IDX_INPUT_SRC  = 16'h3F53;
  localparam logic [15:0] IDX_RISE_DB    = 16'h3F54;
  localparam logic [15:0] IDX_FALL_DB    = 16'h3F55;
  localparam logic [15:0] IDX_MAIN_CTRL  = 16'h3F56;
  localparam logic [15:0] IDX_POL_CTRL   = 16'h3F57;
  localparam logic [15:0] IDX_SHUT_CTRL  = 16'h3F58;
  localparam logic [15:0] IDX_SHUT_SRC   = 16'h3F59;
  localparam logic [15:0] IDX_STEERING   = 16'h3F5A;

  // ---------------------------------------------------------------
  // field positions and widths
  // ---------------------------------------------------------------
  localparam int unsigned CON0_EN_BIT  = 7;
  localparam int unsigned CON0_LD_BIT  = 6;
  localparam int unsigned MODE_W       = 3;
  localparam int unsigned CON1_IN_BIT  = 5;
  localparam int unsigned AS0_SHUT_BIT = 7;
  localparam int unsigned AS0_REN_BIT  = 6;
  localparam int unsigned SHUTDOWN_LEVEL_BD_LSB     = 4;
  localparam int unsigned SHUTDOWN_LEVEL_AC_LSB     = 2;
  localparam int unsigned LVL_W        = 2;
  localparam int unsigned STR_OVR_LSB  = 4;
  localparam int unsigned LEG_W        = 4;
  localparam int unsigned SRC_W        = 7;
  localparam int unsigned DB_W         = 6;
  localparam int unsigned IS_W         = 4;
  localparam int unsigned LEG_A        = 0;
  localparam int unsigned LEG_B        = 1;
  localparam int unsigned LEG_C        = 2;
  localparam int unsigned LEG_D        = 3;

  // ---------------------------------------------------------------
  // codes and reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] MODE_FWD     = 3'h2;
  localparam logic [2:0] MODE_REV     = 3'h3;
  localparam logic [1:0] LVL_INACTIVE = 2'h0;
  localparam logic [1:0] LVL_LOW      = 2'h2;
  localparam logic [1:0] LVL_HIGH     = 2'h3;
  localparam logic [7:0] REG_RESET    = 8'h00;

endpackage : fbw_pkg

// File: fbw_input_pick.sv
// Purpose: picks the modulating input and flags its rising edge
// Assumes: inputs synchronous to pclk
// Notes:   a select beyond the input count reads as constant low
`timescale 1ns/1ps
module fbw_input_pick #(
  parameter int unsigned IN_COUNT = 16
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    clk_en,
  input  wire logic [IN_COUNT-1:0]     mod_inputs,
  input  wire logic [fbw_pkg::IS_W-1:0] sel,
  output logic                         level,
  output logic                         rise
);
  import fbw_pkg::*;

  typedef struct packed {
    logic level;
    logic rise;
  } fbw_pick_state_t;

  fbw_pick_state_t r;
  fbw_pick_state_t next_r;

  // ---------------------------------------------------------------
  // selection and edge
  // ---------------------------------------------------------------
  // edge taken against the registered level so rise is one cycle
  always_comb begin
    logic picked;
    picked = 1'b0;
    if (32'(sel) < IN_COUNT) begin
      picked = mod_inputs[sel];
    end
    next_r.level = picked;
    next_r.rise  = picked && !r.level;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign level = r.level;
  assign rise  = r.rise;

endmodule // fbw_input_pick

// File: fbw_dead_timer.sv
// Purpose: counts the direction-switch dead band
// Assumes: tick is high for each cycle of the selected clock source
// Notes:   a limit of zero gives no dead band at all
`timescale 1ns/1ps
module fbw_dead_timer #(
  parameter int unsigned CNT_W = 6
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clk_en,
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] limit,
  input  wire logic             tick,
  output logic                  busy
);
  import fbw_pkg::*;

  typedef struct packed {
    logic             busy;
    logic [CNT_W-1:0] cnt;
  } fbw_timer_state_t;

  fbw_timer_state_t r;
  fbw_timer_state_t next_r;

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  // a restart while busy begins a fresh full interval
  always_comb begin
    next_r = r;
    if (start) begin
      next_r.busy = (limit != '0);
      next_r.cnt  = '0;
    end else if (r.busy && tick) begin
      if (r.cnt == limit - CNT_W'(1)) begin  // RQ16
        next_r.busy = 1'b0;
      end else begin
        next_r.cnt = r.cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign busy = r.busy;

  property p_dead_len;
    @(posedge pclk) disable iff (!presetn)
    $fell(r.busy) && !$past(start)
      |-> $past(r.cnt) == $past(limit) - CNT_W'(1) && $past(tick);
  endproperty
  a_dead_len: assert property (p_dead_len) // RQ16
    else $error("dead band ended before its count");

endmodule // fbw_dead_timer

// File: fbw_bridge_core.sv
// Purpose: full-bridge waveform steering with an APB register map
// Assumes: all inputs synchronous to pclk; APB slave with no wait state
// Notes:   outputs, read data and handshake all come from flip-flops
// Notes on behaviour
// (RQ1) mode field picks forward or reverse in full-bridge operation
// (RQ2) new direction waits for next rising edge of modulated input
// (RQ3) at direction change outputs A and C swap static states
// (RQ4) old modulated leg goes inactive, the other leg starts modulating
// (RQ5) new modulated leg stays off until the dead band elapses
// (RQ6) dead band only at direction change, only on modulated leg
// (RQ7) static legs A and C switch together with no dead band
// (RQ8) software should lower duty for one period before reversing
// (RQ9) main control: enable bit 7, load bit 6, mode low bits
// (RQ10) steering: override levels D..A bits 7:4, enables bits 3:0
// (RQ11) shutdown sources: seven enables in bits 6:0, bit 7 unused
// (RQ12) shutdown control: state, restart, B/D level, A/C level
// (RQ13) control 1: input level bit 5, polarity D..A bits 3:0
// (RQ14) fall dead band and rise dead band in low six bits
// (RQ15) input source select low bits, clock select bit 0
// (RQ16) dead band counts selected clock cycles up to the count
`timescale 1ns/1ps
module fbw_bridge_core #(
  parameter int unsigned IN_COUNT = 16
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      clk_en,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [fbw_pkg::ADDR_W-1:0] paddr,
  input  wire logic [fbw_pkg::DATA_W-1:0] pwdata,
  input  wire logic [IN_COUNT-1:0]       mod_inputs,
  input  wire logic [fbw_pkg::SRC_W-1:0] shutdown_src,
  input  wire logic                      alt_clk_tick,
  output logic [fbw_pkg::DATA_W-1:0]     prdata,
  output logic                           pready,
  output logic                           pslverr,
  output logic                           bridge_out_a,
  output logic                           bridge_out_b,
  output logic                           bridge_out_c,
  output logic                           bridge_out_d
);
  import fbw_pkg::*;

  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  if (IN_COUNT < 1 || IN_COUNT > (1 << IS_W)) begin : g_bad_count
    $error("IN_COUNT must lie between 1 and 16");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              clk_sel;
    logic [IS_W-1:0]   in_sel;
    logic [DB_W-1:0]   rise_dead_count;
    logic [DB_W-1:0]   fall_dead_count;
    logic [DB_W-1:0]   dead_active;
    logic              en;
    logic [MODE_W-1:0] mode;
    logic [LEG_W-1:0]  pol;
    logic              shut;
    logic              ren;
    logic [LVL_W-1:0]  shutdown_level_bd;
    logic [LVL_W-1:0]  shutdown_level_ac;
    logic [SRC_W-1:0]  src_en;
    logic [LEG_W-1:0]  ovr;
    logic [LEG_W-1:0]  steer;
    logic              dir_rev;
    logic [LEG_W-1:0]  raw;
    logic [LEG_W-1:0]  outs;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
  } fbw_core_state_t;

  fbw_core_state_t r;
  fbw_core_state_t next_r;

  logic mod_level;
  logic in_rise;
  logic db_busy;
  logic db_start;
  logic db_tick;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
    return {idx[13:0], 2'b00};
  endfunction

  function automatic logic is_bridge(input logic [MODE_W-1:0] m);
    return (m == MODE_FWD) || (m == MODE_REV);
  endfunction

  // shutdown drive: inactive code keeps the polarity's idle level
  function automatic logic shut_level(input logic [LVL_W-1:0] code,
                                      input logic pol);
    case (code)
      LVL_LOW:  return 1'b0;
      LVL_HIGH: return 1'b1;
      default:  return pol;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------
  fbw_input_pick #(
    .IN_COUNT (IN_COUNT)
  ) u_pick (
    .pclk       (pclk),
    .presetn    (presetn),
    .clk_en     (clk_en),
    .mod_inputs (mod_inputs),
    .sel        (r.in_sel),
    .level      (mod_level),
    .rise       (in_rise)
  );

  // direction change is taken only on an input rising edge
  assign db_start = in_rise && is_bridge(r.mode)
                    && (r.dir_rev != r.mode[0]);  // RQ2
  // clock select: pclk itself or the alternate tick
  assign db_tick  = r.clk_sel ? alt_clk_tick : 1'b1;  // RQ16

  fbw_dead_timer #(
    .CNT_W (DB_W)
  ) u_dead (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .start   (db_start),
    .limit   (r.dead_active),
    .tick    (db_tick),
    .busy    (db_busy)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [7:0]       rd;
    logic             unmapped;
    logic             wr;
    logic             any_src;
    logic             sw_set;
    logic             sw_clr;
    logic [LEG_W-1:0] raw;
    rd       = REG_RESET;
    unmapped = 1'b0;
    sw_set   = 1'b0;
    sw_clr   = 1'b0;
    raw      = '0;
    wr       = 1'b0;
    any_src  = 1'b0;
    next_r   = r;

    // read decode, taken in the setup phase
    case (paddr)
      byte_addr(IDX_CLOCK_SRC): rd = {7'h00, r.clk_sel};  // RQ15
      byte_addr(IDX_INPUT_SRC): rd = {4'h0, r.in_sel};  // RQ15
      byte_addr(IDX_RISE_DB):   rd = {2'h0, r.rise_dead_count};  // RQ14
      byte_addr(IDX_FALL_DB):   rd = {2'h0, r.fall_dead_count};  // RQ14
      byte_addr(IDX_MAIN_CTRL): rd = {r.en, 4'h0, r.mode};  // RQ9
      byte_addr(IDX_POL_CTRL):  rd = {2'h0, mod_level, 1'b0, r.pol};  // RQ13
      byte_addr(IDX_SHUT_CTRL): rd = {r.shut, r.ren, r.shutdown_level_bd,
                                      r.shutdown_level_ac, 2'h0};  // RQ12
      byte_addr(IDX_SHUT_SRC):  rd = {1'b0, r.src_en};  // RQ11
      byte_addr(IDX_STEERING):  rd = {r.ovr, r.steer};  // RQ10
      default:                  unmapped = 1'b1;
    endcase

    // answer one cycle after setup, so pready starts the access phase
    next_r.pready = psel && !penable;
    if (psel && !penable) begin
      next_r.prdata  = {24'h00_0000, rd};
      next_r.pslverr = unmapped;
    end

    // writes land on the access edge that sees pready high
    wr = psel && penable && pwrite && r.pready && !r.pslverr;
    if (wr) begin
      case (paddr)
        byte_addr(IDX_CLOCK_SRC): next_r.clk_sel = pwdata[0];  // RQ15
        byte_addr(IDX_INPUT_SRC): next_r.in_sel = pwdata[IS_W-1:0];  // RQ15
        byte_addr(IDX_RISE_DB):
          next_r.rise_dead_count = pwdata[DB_W-1:0];  // RQ14
        byte_addr(IDX_FALL_DB):
          next_r.fall_dead_count = pwdata[DB_W-1:0];  // RQ14
        byte_addr(IDX_MAIN_CTRL): begin
          next_r.en   = pwdata[CON0_EN_BIT];  // RQ9
          next_r.mode = pwdata[MODE_W-1:0];  // RQ1
          // load moves the count into the working copy; reads as 0
          if (pwdata[CON0_LD_BIT]) begin
            next_r.dead_active = r.rise_dead_count;
          end
        end
        byte_addr(IDX_POL_CTRL):  next_r.pol = pwdata[LEG_W-1:0];  // RQ13
        byte_addr(IDX_SHUT_CTRL): begin
          sw_set = pwdata[AS0_SHUT_BIT];  // RQ12
          sw_clr = !pwdata[AS0_SHUT_BIT];
          next_r.ren = pwdata[AS0_REN_BIT];
          next_r.shutdown_level_bd = pwdata[SHUTDOWN_LEVEL_BD_LSB +: LVL_W];
          next_r.shutdown_level_ac = pwdata[SHUTDOWN_LEVEL_AC_LSB +: LVL_W];
        end
        byte_addr(IDX_SHUT_SRC):  next_r.src_en = pwdata[SRC_W-1:0];  // RQ11
        byte_addr(IDX_STEERING): begin
          next_r.ovr   = pwdata[STR_OVR_LSB +: LEG_W];  // RQ10
          next_r.steer = pwdata[LEG_W-1:0];
        end
        default: ;
      endcase
    end

    // shutdown: a live source beats any clear in the same cycle
    any_src = |(shutdown_src & r.src_en);  // RQ11
    if (sw_clr || (r.ren && in_rise && !any_src)) begin
      next_r.shut = 1'b0;
    end
    if (sw_set || any_src) begin
      next_r.shut = 1'b1;
    end

    // direction follows the mode only on the input's rising edge
    if (db_start) begin
      next_r.dir_rev = r.mode[0];  // RQ2
    end

    // leg drive before polarity
    if (r.en && is_bridge(r.mode)) begin
      raw[LEG_A] = !r.dir_rev;  // RQ3
      raw[LEG_C] = r.dir_rev;  // RQ7
      raw[LEG_B] = r.dir_rev && mod_level && !db_busy;  // RQ4
      raw[LEG_D] = !r.dir_rev && mod_level && !db_busy;  // RQ5 RQ6
    end else if (r.en) begin
      for (int i = 0; i < LEG_W; i++) begin
        raw[i] = r.steer[i] ? mod_level : r.ovr[i];
      end
    end
    next_r.raw = raw;

    // polarity, then shutdown override per pair
    for (int i = 0; i < LEG_W; i++) begin
      if (r.shut) begin
        next_r.outs[i] = shut_level((i % 2 == 0) ? r.shutdown_level_ac
                                                 : r.shutdown_level_bd,
                                    r.pol[i]);
      end else begin
        next_r.outs[i] = raw[i] ^ r.pol[i];  // RQ13
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign prdata       = r.prdata;
  assign pready       = r.pready;
  assign pslverr      = r.pslverr;
  assign bridge_out_a = r.outs[LEG_A];
  assign bridge_out_b = r.outs[LEG_B];
  assign bridge_out_c = r.outs[LEG_C];
  assign bridge_out_d = r.outs[LEG_D];

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_static_legs;
    @(posedge pclk) disable iff (!presetn)
    clk_en && r.en && is_bridge(r.mode)
      |=> r.raw[LEG_A] == !$past(r.dir_rev)
          && r.raw[LEG_C] == $past(r.dir_rev);
  endproperty
  a_static_legs: assert property (p_static_legs) // RQ3
    else $error("static legs do not match direction");

  property p_dir_on_edge;
    @(posedge pclk) disable iff (!presetn)
    $changed(r.dir_rev) |-> $past(in_rise) && $past(clk_en);
  endproperty
  a_dir_on_edge: assert property (p_dir_on_edge) // RQ2
    else $error("direction changed without input rising edge");

  property p_mode_dir;
    @(posedge pclk) disable iff (!presetn)
    clk_en && db_start |=> r.dir_rev == $past(r.mode[0]);
  endproperty
  a_mode_dir: assert property (p_mode_dir) // RQ1
    else $error("direction does not follow mode");

  property p_old_leg_off;
    @(posedge pclk) disable iff (!presetn)
    clk_en && db_start && r.en && r.mode == MODE_REV
      |=> ##1 !r.raw[LEG_D];
  endproperty
  a_old_leg_off: assert property (p_old_leg_off) // RQ4
    else $error("old modulated leg still driven");

  property p_hold_off;
    @(posedge pclk) disable iff (!presetn)
    clk_en && db_busy |=> !r.raw[LEG_B] && !r.raw[LEG_D];
  endproperty
  a_hold_off: assert property (p_hold_off) // RQ5
    else $error("modulated leg driven inside dead band");

  property p_mod_follows;
    @(posedge pclk) disable iff (!presetn)
    clk_en && r.en && r.mode == MODE_FWD && !r.dir_rev && !db_busy
      |=> r.raw[LEG_D] == $past(mod_level);
  endproperty
  a_mod_follows: assert property (p_mod_follows) // RQ6
    else $error("modulated leg delayed outside direction change");

  property p_polarity;
    @(posedge pclk) disable iff (!presetn)
    clk_en && !r.shut |=> r.outs == (r.raw ^ $past(r.pol));
  endproperty
  a_polarity: assert property (p_polarity) // RQ13
    else $error("polarity not applied to outputs");

  property p_shut_src;
    @(posedge pclk) disable iff (!presetn)
    clk_en && |(shutdown_src & r.src_en) |=> r.shut;
  endproperty
  a_shut_src: assert property (p_shut_src) // RQ11
    else $error("enabled shutdown source ignored");

  property p_apb_answer;
    @(posedge pclk) disable iff (!presetn)
    clk_en && psel && !penable |=> pready ##1 !pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer) // no wait state, as in the header
    else $error("pready not a single cycle after setup");

  c_dir_change: cover property (@(posedge pclk) disable iff (!presetn)
    db_start ##1 db_busy);
  c_shutdown: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(r.shut));
  c_apb_write: cover property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && pready);

endmodule // fbw_bridge_core

// File: fbw_switch_model.sv
// Purpose: bridge power switches seen from the four drive pins
// Assumes: a high drive turns its switch on; legs are a/b and c/d
// Notes:   OFF_DLY models slow turn-off; 0 gives prompt switches
`timescale 1ns/1ps
module fbw_switch_model #(
  parameter int unsigned OFF_DLY = 0
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clear,
  input  wire logic drive_a,
  input  wire logic drive_b,
  input  wire logic drive_c,
  input  wire logic drive_d,
  output logic      shoot
);
  // ---------------------------------------------------------------
  // conduction per switch
  // ---------------------------------------------------------------
  logic [3:0][3:0] hold;
  logic [3:0]      drv;
  logic [3:0]      on;
  assign drv = {drive_d, drive_c, drive_b, drive_a};
  // a switch keeps conducting while its turn-off runs out
  assign on  = drv | {hold[3] != 0, hold[2] != 0, hold[1] != 0,
                      hold[0] != 0};
  // sticky overlap flag: both switches of one leg conducting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold  <= '0;
      shoot <= 1'b0;
    end else begin
      for (int i = 0; i < 4; i++)
        hold[i] <= drv[i] ? 4'(OFF_DLY) : hold[i] - 4'(hold[i] != 0);
      shoot <= !clear & (shoot | (on[0] & on[1]) | (on[2] & on[3]));
    end
  end
endmodule // fbw_switch_model

// File: tb.sv
// Purpose: self-checking bench for the full-bridge steering block
// Assumes: apb slave answers when it likes; the bench only waits
// Notes:   random data from an lfsr seeded at 97
`timescale 1ns/1ps
module tb;
  import fbw_pkg::*;
  // ---------------------------------------------------------------
  // signals and tables
  // ---------------------------------------------------------------
  localparam int SEL = 5;
  localparam logic [15:0] IDX [9] = '{IDX_CLOCK_SRC, IDX_INPUT_SRC,
    IDX_RISE_DB, IDX_FALL_DB, IDX_MAIN_CTRL, IDX_POL_CTRL,
    IDX_SHUT_CTRL, IDX_SHUT_SRC, IDX_STEERING};
  localparam logic [7:0] MSK [9] = '{8'h01, 8'h0F, 8'h3F, 8'h3F,
    8'h87, 8'h0F, 8'hFC, 8'h7F, 8'hFF};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        alt_clk_tick = 1'b0;
  logic        clear = 1'b0;
  logic        lvl = 1'b0;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [15:0] mod_inputs = '0;
  logic [6:0]  shutdown_src = '0;
  logic [7:0]  seed = 8'h61;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        shoot;
  wire  [3:0]  outs;
  int          fail_count = 0;
  int          checks = 0;
  int          cyc = 0;

  // clock; dead-band tick every fourth cycle
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    alt_clk_tick <= (cyc % 4 == 0);
  end

  fbw_bridge_core u_fbw_bridge_core (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .mod_inputs(mod_inputs), .shutdown_src(shutdown_src),
    .alt_clk_tick(alt_clk_tick), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bridge_out_a(outs[0]), .bridge_out_b(outs[1]),
    .bridge_out_c(outs[2]), .bridge_out_d(outs[3]));
  fbw_switch_model u_fbw_switch_model (
    .pclk(pclk), .presetn(presetn), .clear(clear), .drive_a(outs[0]),
    .drive_b(outs[1]), .drive_c(outs[2]), .drive_d(outs[3]),
    .shoot(shoot));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] lfsr();
    seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
    return seed;
  endfunction
  // {d,c,b,a}: forward holds a on and modulates d, reverse c and b
  function automatic logic [3:0] fb_exp(logic [2:0] m, logic i,
                                        logic [3:0] p);
    return (m[0] ? {2'b01, i, 1'b0} : {i, 3'b001}) ^ p;
  endfunction
  task automatic chk_reg(string n, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_out(string n, logic [3:0] e);
    checks++;
    if (outs !== e) begin
      fail_count++;
      $display("wrong value %s expected %b seen %b", n, e, outs);
    end
  endtask
  task automatic wait_n(int n);
    repeat (n) @(posedge pclk);
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(logic w, logic [15:0] a, logic [7:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk_reg("pready", 1, 32'(pready));
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(logic [15:0] i, logic [7:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, i << 2, d, rd, er);
  endtask
  task automatic rdc(logic [15:0] i, logic [31:0] e);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, i << 2, 8'h00, rd, er);
    chk_reg("read data", e, rd);
    chk_reg("slave error", 0, 32'(er));
  endtask
  // selected input set, other candidates random
  task automatic set_in(logic v);
    @(posedge pclk);
    lvl = v;
    mod_inputs <= {lfsr(), lfsr()} & ~16'h0020 | (16'(v) << SEL);
  endtask
  // reversal: low duty first, then rise, swap and dead band
  task automatic dir_to(logic [2:0] m, int lo, int hi);
    int n;
    set_in(1'b0);
    wait_n(4);
    clear <= 1'b1;
    wr(IDX_MAIN_CTRL, {5'h10, m});
    clear <= 1'b0;
    wait_n(4);
    chk_out("before rise", fb_exp(m ^ 3'h1, 1'b0, 4'h0));
    set_in(1'b1);
    n = 0;
    while (outs[0] !== !m[0] && n < 10) begin
      wait_n(1);
      n++;
    end
    chk_out("at switch", fb_exp(m, lo == 0, 4'h0));
    n = 0;
    while (outs[m[0] ? 1 : 3] !== 1'b1 && n < 40) begin
      wait_n(1);
      n++;
    end
    chk_reg("dead band", 1, 32'(n >= lo && n <= hi));
    chk_out("after dead band", fb_exp(m, 1'b1, 4'h0));
    set_in(1'b0);
    wait_n(3);
    chk_out("mod low", fb_exp(m, 1'b0, 4'h0));
    set_in(1'b1);
    wait_n(3);
    chk_out("mod high", fb_exp(m, 1'b1, 4'h0));
    chk_reg("leg overlap", 0, 32'(shoot));
  endtask
  task automatic print_verdict();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic        e;
    logic [7:0]  v;
    wait_n(10);
    presetn <= 1'b1;
    // reset values, then random write and masked readback
    for (int r = 0; r < 9; r++) begin
      rdc(IDX[r], 32'h0);
      v = lfsr();
      wr(IDX[r], v);
      rdc(IDX[r], {24'h0, v & MSK[r]});
      wr(IDX[r], 8'h00);
    end
    apb(1'b0, 16'h0000, 8'h00, d, e);
    chk_reg("unmapped data", 0, d);
    chk_reg("unmapped error", 1, 32'(e));
    wr(IDX_INPUT_SRC, 8'(SEL));
    set_in(1'b1);
    wait_n(3);
    rdc(IDX_POL_CTRL, 32'h20);
    wr(IDX_RISE_DB, 8'h03);
    wr(IDX_MAIN_CTRL, {5'h18, MODE_FWD});
    for (int i = 0; i < 2; i++) begin
      set_in(i[0]);
      wait_n(3);
      chk_out("forward", fb_exp(MODE_FWD, i[0], 4'h0));
    end
    dir_to(MODE_REV, 3, 6);
    dir_to(MODE_FWD, 3, 6);
    // polarity inverts every leg
    wr(IDX_POL_CTRL, 8'h0F);
    for (int i = 0; i < 2; i++) begin
      set_in(i[0]);
      wait_n(3);
      chk_out("polarity", fb_exp(MODE_FWD, i[0], 4'hF));
    end
    wr(IDX_POL_CTRL, 8'h00);
    wr(IDX_CLOCK_SRC, 8'h01);
    dir_to(MODE_REV, 9, 18);
    wr(IDX_CLOCK_SRC, 8'h00);
    wr(IDX_RISE_DB, 8'h00);
    wr(IDX_MAIN_CTRL, {5'h18, MODE_REV});
    dir_to(MODE_FWD, 0, 2);
    // every mode code outside full-bridge steers
    wr(IDX_STEERING, 8'hA5);
    for (int m = 0; m < 8; m++) begin
      if (m == 2 || m == 3)
        continue;
      wr(IDX_MAIN_CTRL, {5'h10, 3'(m)});
      set_in(lfsr() > 8'h7F);
      wait_n(4);
      chk_out("steering", {1'b1, lvl, 1'b1, lvl});
    end
    wr(IDX_STEERING, 8'h00);
    // each shutdown source forces the programmed levels
    wr(IDX_MAIN_CTRL, {5'h10, MODE_FWD});
    wr(IDX_SHUT_CTRL, {2'b00, LVL_HIGH, LVL_LOW, 2'b00});
    for (int i = 0; i < 7; i++) begin
      wr(IDX_SHUT_SRC, 8'(1 << i));
      shutdown_src <= 7'(1 << i);
      wait_n(4);
      chk_out("shutdown", 4'b1010);
      rdc(IDX_SHUT_CTRL, {24'h0, 2'b10, LVL_HIGH, LVL_LOW, 2'b00});
      shutdown_src <= '0;
      wr(IDX_SHUT_CTRL, {2'b00, LVL_HIGH, LVL_LOW, 2'b00});
      wait_n(4);
      chk_out("restart", fb_exp(MODE_FWD, lvl, 4'h0));
    end
    // disabled block rests at the polarity levels
    wr(IDX_POL_CTRL, 8'h05);
    wr(IDX_MAIN_CTRL, {5'h00, MODE_FWD});
    wait_n(3);
    chk_out("disabled", 4'h5);
    print_verdict();
  end

  // watchdog well beyond the several hundred cycles of the run
  initial begin
    #300us;
    fail_count++;
    print_verdict();
  end
endmodule // tb
